// ===== pkg/pid_loop_pkg.sv
package pid_loop_pkg;

  // ************************************************************
  // Fixed point formats
  // ************************************************************
  // Normalized values are signed Q2.14, so 1.0 is 16'h4000.
  // Gains and coefficients are unsigned Q8.8, so 1.0 is 16'h0100.
  localparam int FRAC_BITS = 8;
  localparam logic signed [15:0] NORM_ZERO = 16'sh0000;
  localparam logic signed [15:0] NORM_ONE = 16'sh4000;
  localparam logic signed [39:0] NORM_ZERO_W = 40'sh00_0000_0000;
  localparam logic signed [39:0] NORM_ONE_W = 40'sh00_0000_4000;
  localparam logic [15:0] GAIN_ZERO = 16'h0000;
  localparam logic [15:0] ITIME_OFF = 16'h270f;
  localparam logic [15:0] DTIME_OFF = 16'h0000;
  localparam logic [15:0] TIME_ZERO = 16'h0000;
  localparam logic [31:0] COEF_ZERO = 32'h0000_0000;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic signed [15:0] RST_VALUE = 16'sh0000;
  localparam logic RST_XFER_TWO = 1'b0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10
  } calc_st_t;

  typedef enum logic [2:0] {
    MODE_MANUAL = 3'b001,
    MODE_AUTO = 3'b010,
    MODE_CASCADE = 3'b100
  } mode_t;

  typedef struct packed {
    logic [15:0] proportional_gain;
    logic [15:0] integral_time;
    logic [15:0] derivative_time;
    logic [15:0] sample_period;
    logic freeze_bias;
    logic velocity;
    logic reverse_acting;
    logic step_bias;
  } cfg_t;

  typedef struct packed {
    logic signed [15:0] high_high;
    logic signed [15:0] high;
    logic signed [15:0] low;
    logic signed [15:0] low_low;
    logic signed [15:0] yellow_dev;
    logic signed [15:0] orange_dev;
    logic signed [15:0] rate;
    logic signed [15:0] hysteresis;
  } limits_t;

  typedef struct packed {
    logic high_high;
    logic high;
    logic low;
    logic low_low;
    logic yellow;
    logic orange;
    logic rate;
  } alarm_t;

  localparam alarm_t ALARM_NONE = 7'h00;

endpackage : pid_loop_pkg

// ===== rtl/pid_loop_controller.sv
// Contract
// - Bias accumulates integral times error; output is P minus D on PV change plus bias.
// - Computed control output is clamped into zero to one.
// - Out of range: freeze bias if selected, else back-calculate bias from clamped output.
// - Setpoint step scales bias by new over old, or old over new when reverse.
// - Scaled bias is clamped into zero to one.
// - Integral time 9999 removes integral action; bias then changes only by setpoint step scaling, back-calculation or manual to automatic transfer.
// - Derivative time zero removes derivative action.
// - Integral coefficient is gain times period over integral time, or without gain.
// - Derivative coefficient is gain times derivative time over period, or without gain.
// - Velocity form adds gain times error change plus coefficient times PV second difference.
// - Manual to automatic sets setpoint to PV with transfer type one and, in position form, bias to output.
// - Two transfer types, chosen when the loop is configured.
// - Four PV limit alarms: high-high, high, low, low-low.
// - Yellow and orange deviation alarms when PV strays past their limits.
// - Rate alarm when PV changes faster than the rate limit.
// - Limit and deviation alarms assert past threshold with a hysteresis band.
// - Loop runs in exactly one of manual, automatic or cascade.
// - Manual output comes from the operator; alarms are still monitored.
// - Automatic mode computes the output and monitors alarms.
// - Cascade acts as automatic with setpoint from another loop's output.
module pid_loop_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic cfg_load,
  input wire logic transfer_type_two,
  input wire pid_loop_pkg::cfg_t cfg,
  input wire pid_loop_pkg::limits_t limits,
  input wire pid_loop_pkg::mode_t mode_sel,
  input wire logic setpoint_load,
  input wire logic signed [15:0] setpoint_value,
  input wire logic signed [15:0] cascade_setpoint,
  input wire logic signed [15:0] manual_output,
  input wire logic signed [15:0] process_value,
  output logic signed [15:0] control_output,
  output logic signed [15:0] output_change,
  output logic signed [15:0] bias_term,
  output logic signed [15:0] active_setpoint,
  output pid_loop_pkg::mode_t active_mode,
  output pid_loop_pkg::alarm_t alarms,
  output logic sample_done
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    pid_loop_pkg::calc_st_t st;
    pid_loop_pkg::mode_t mode;
    logic was_manual;
    logic xfer_two;
    logic signed [15:0] pv;
    logic signed [15:0] pv_prev;
    logic signed [15:0] pv_prev2;
    logic signed [15:0] sp;
    logic signed [15:0] sp_prev;
    logic signed [15:0] sp_reg;
    logic signed [15:0] err_prev;
    logic signed [15:0] bias;
    logic signed [15:0] out;
    logic signed [15:0] delta;
    pid_loop_pkg::alarm_t alarm;
    logic done;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic signed [39:0] sx(input logic signed [15:0] v);
    return {{24{v[15]}}, v};
  endfunction : sx

  function automatic logic signed [39:0] mulq(input logic signed [39:0] a,
                                               input logic [31:0] k);
    logic signed [39:0] p;
    p = a * $signed({8'h00, k});
    return p >>> pid_loop_pkg::FRAC_BITS;
  endfunction : mulq

  function automatic logic signed [15:0] clamp01(input logic signed [39:0] v);
    if (v < pid_loop_pkg::NORM_ZERO_W) begin
      return pid_loop_pkg::NORM_ZERO;
    end else if (v > pid_loop_pkg::NORM_ONE_W) begin
      return pid_loop_pkg::NORM_ONE;
    end
    return v[15:0];
  endfunction : clamp01

  // Alarm above a limit; it holds inside the band so PV noise cannot chatter it.
  function automatic logic hyst_above(input logic act, input logic signed [39:0] val,
                                      input logic signed [39:0] lim,
                                      input logic signed [39:0] hyst);
    if (val > lim) begin
      return 1'b1;
    end else if (val < lim - hyst) begin
      return 1'b0;
    end
    return act;
  endfunction : hyst_above

  function automatic logic signed [39:0] absw(input logic signed [39:0] v);
    return (v < pid_loop_pkg::NORM_ZERO_W) ? -v : v;
  endfunction : absw

  // ************************************************************
  // Coefficients
  // ************************************************************
  logic [31:0] ki;
  logic [31:0] kr;
  logic [31:0] kc_w;
  logic [31:0] ti_w;
  logic [31:0] td_w;
  logic [31:0] ts_w;

  always_comb begin
    kc_w = {16'h0000, cfg.proportional_gain};
    ti_w = {16'h0000, cfg.integral_time};
    td_w = {16'h0000, cfg.derivative_time};
    ts_w = {16'h0000, cfg.sample_period};
    if (cfg.integral_time == pid_loop_pkg::ITIME_OFF ||
        cfg.integral_time == pid_loop_pkg::TIME_ZERO) begin
      ki = pid_loop_pkg::COEF_ZERO;
    end else if (cfg.proportional_gain != pid_loop_pkg::GAIN_ZERO) begin
      ki = (kc_w * ts_w) / ti_w;
    end else begin
      ki = {8'h00, cfg.sample_period, 8'h00} / ti_w;
    end
    if (cfg.derivative_time == pid_loop_pkg::DTIME_OFF ||
        cfg.sample_period == pid_loop_pkg::TIME_ZERO) begin
      kr = pid_loop_pkg::COEF_ZERO;
    end else if (cfg.proportional_gain != pid_loop_pkg::GAIN_ZERO) begin
      kr = (kc_w * td_w) / ts_w;
    end else begin
      kr = {8'h00, cfg.derivative_time, 8'h00} / ts_w;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  logic signed [39:0] err;
  logic signed [39:0] p_term;
  logic signed [39:0] d_term;
  logic signed [39:0] bias_s;
  logic signed [39:0] bias_x;
  logic signed [39:0] m_raw;
  logic signed [39:0] dm;
  logic signed [39:0] dev;
  logic signed [39:0] hyst;
  logic signed [15:0] m_clamped;
  logic step;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    err = sx(cur_ff.sp) - sx(cur_ff.pv);
    p_term = mulq(err, kc_w);
    d_term = mulq(sx(cur_ff.pv) - sx(cur_ff.pv_prev), kr);
    step = cfg.step_bias && cur_ff.sp != cur_ff.sp_prev &&
           cur_ff.sp != pid_loop_pkg::NORM_ZERO && cur_ff.sp_prev != pid_loop_pkg::NORM_ZERO;
    bias_s = sx(cur_ff.bias);
    if (step) begin
      if (cfg.reverse_acting) begin
        bias_s = (sx(cur_ff.bias) * sx(cur_ff.sp_prev)) / sx(cur_ff.sp);
      end else begin
        bias_s = (sx(cur_ff.bias) * sx(cur_ff.sp)) / sx(cur_ff.sp_prev);
      end
      bias_s = sx(clamp01(bias_s));
    end
    bias_x = bias_s + mulq(err, ki);
    m_raw = p_term - d_term + bias_x;
    m_clamped = clamp01(m_raw);
    dm = mulq(err - sx(cur_ff.err_prev), kc_w) +
         mulq(sx(cur_ff.pv) - (sx(cur_ff.pv_prev) <<< 1) + sx(cur_ff.pv_prev2), ki);
    dev = sx(cur_ff.pv) - sx(cur_ff.sp);
    hyst = sx(limits.hysteresis);

    if (cfg_load) begin
      nxt_cur.xfer_two = transfer_type_two;
    end
    if (setpoint_load) begin
      nxt_cur.sp_reg = setpoint_value;
    end

    case (cur_ff.st)
      pid_loop_pkg::ST_IDLE: begin
        if (sample_tick) begin
          // PV, setpoint and mode are frozen here; cfg, limits and manual_output are still read in ST_CALC.
          nxt_cur.pv = process_value;
          nxt_cur.pv_prev = cur_ff.pv;
          nxt_cur.pv_prev2 = cur_ff.pv_prev;
          nxt_cur.sp_prev = cur_ff.sp;
          nxt_cur.was_manual = (cur_ff.mode == pid_loop_pkg::MODE_MANUAL);
          case (mode_sel)
            pid_loop_pkg::MODE_AUTO: begin
              nxt_cur.mode = pid_loop_pkg::MODE_AUTO;
              nxt_cur.sp = setpoint_load ? setpoint_value : cur_ff.sp_reg;
            end
            pid_loop_pkg::MODE_CASCADE: begin
              nxt_cur.mode = pid_loop_pkg::MODE_CASCADE;
              nxt_cur.sp = cascade_setpoint;
            end
            default: begin
              nxt_cur.mode = pid_loop_pkg::MODE_MANUAL;
              nxt_cur.sp = setpoint_load ? setpoint_value : cur_ff.sp_reg;
            end
          endcase
          nxt_cur.st = pid_loop_pkg::ST_CALC;
        end
      end
      pid_loop_pkg::ST_CALC: begin
        nxt_cur.st = pid_loop_pkg::ST_IDLE;
        nxt_cur.done = 1'b1;
        nxt_cur.err_prev = err[15:0];
        if (cur_ff.mode == pid_loop_pkg::MODE_MANUAL) begin
          nxt_cur.out = manual_output;
          nxt_cur.delta = pid_loop_pkg::NORM_ZERO;
        end else if (cur_ff.was_manual) begin
          // The output is held this sample, which is what makes the switch bumpless.
          nxt_cur.delta = pid_loop_pkg::NORM_ZERO;
          if (!cur_ff.xfer_two && cur_ff.mode == pid_loop_pkg::MODE_AUTO) begin
            nxt_cur.err_prev = pid_loop_pkg::NORM_ZERO;
            nxt_cur.sp_reg = cur_ff.pv;
            nxt_cur.sp = cur_ff.pv;
          end
          if (!cfg.velocity) begin
            nxt_cur.bias = cur_ff.out;
          end
        end else if (cfg.velocity) begin
          nxt_cur.out = clamp01(sx(cur_ff.out) + dm);
          nxt_cur.delta = nxt_cur.out - cur_ff.out;
        end else begin
          nxt_cur.out = m_clamped;
          nxt_cur.delta = m_clamped - cur_ff.out;
          if (m_raw >= pid_loop_pkg::NORM_ZERO_W && m_raw <= pid_loop_pkg::NORM_ONE_W) begin
            nxt_cur.bias = bias_x[15:0];
          end else if (cfg.freeze_bias) begin
            nxt_cur.bias = bias_s[15:0];
          end else begin
            nxt_cur.bias = clamp01(sx(m_clamped) - p_term + d_term);
          end
        end
        // Alarms run in every mode on the captured sample.
        nxt_cur.alarm.high_high = hyst_above(cur_ff.alarm.high_high, sx(cur_ff.pv),
                                             sx(limits.high_high), hyst);
        nxt_cur.alarm.high = hyst_above(cur_ff.alarm.high, sx(cur_ff.pv),
                                        sx(limits.high), hyst);
        nxt_cur.alarm.low = hyst_above(cur_ff.alarm.low, -sx(cur_ff.pv),
                                       -sx(limits.low), hyst);
        nxt_cur.alarm.low_low = hyst_above(cur_ff.alarm.low_low, -sx(cur_ff.pv),
                                           -sx(limits.low_low), hyst);
        nxt_cur.alarm.yellow = hyst_above(cur_ff.alarm.yellow, absw(dev),
                                          sx(limits.yellow_dev), hyst);
        nxt_cur.alarm.orange = hyst_above(cur_ff.alarm.orange, absw(dev),
                                          sx(limits.orange_dev), hyst);
        nxt_cur.alarm.rate = absw(sx(cur_ff.pv) - sx(cur_ff.pv_prev)) >
                             sx(limits.rate);
      end
      default: begin
        nxt_cur.st = pid_loop_pkg::ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff.st <= pid_loop_pkg::ST_IDLE;
      cur_ff.mode <= pid_loop_pkg::MODE_MANUAL;
      cur_ff.was_manual <= 1'b1;
      cur_ff.xfer_two <= pid_loop_pkg::RST_XFER_TWO;
      cur_ff.pv <= pid_loop_pkg::RST_VALUE;
      cur_ff.pv_prev <= pid_loop_pkg::RST_VALUE;
      cur_ff.pv_prev2 <= pid_loop_pkg::RST_VALUE;
      cur_ff.sp <= pid_loop_pkg::RST_VALUE;
      cur_ff.sp_prev <= pid_loop_pkg::RST_VALUE;
      cur_ff.sp_reg <= pid_loop_pkg::RST_VALUE;
      cur_ff.err_prev <= pid_loop_pkg::RST_VALUE;
      cur_ff.bias <= pid_loop_pkg::RST_VALUE;
      cur_ff.out <= pid_loop_pkg::RST_VALUE;
      cur_ff.delta <= pid_loop_pkg::RST_VALUE;
      cur_ff.alarm <= pid_loop_pkg::ALARM_NONE;
      cur_ff.done <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign control_output = cur_ff.out;
  assign output_change = cur_ff.delta;
  assign bias_term = cur_ff.bias;
  assign active_setpoint = cur_ff.sp;
  assign active_mode = cur_ff.mode;
  assign alarms = cur_ff.alarm;
  assign sample_done = cur_ff.done;

endmodule : pid_loop_controller

// ===== verif/analog_io_model.sv
module analog_io_model (
  input wire logic clk,
  input wire logic signed [15:0] pv_next,
  input wire logic sample_done,
  input wire logic signed [15:0] control_output,
  output logic signed [15:0] process_value,
  output logic signed [15:0] actuator
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Converter behaviour
  // ************************************************************
  // The input converter only presents a new reading at the falling edge, so
  // the loop never sees a value that changes in the middle of its sample.
  initial process_value = 16'sh0000;
  initial actuator = 16'sh0000;
  always @(negedge clk) process_value <= pv_next;
  // The output converter holds the last finished result until the next one.
  always @(posedge clk) if (sample_done) actuator <= control_output;
endmodule : analog_io_model

// ===== verif/pid_loop_controller_monitor.sv
module pid_loop_controller_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_tick,
  input wire pid_loop_pkg::limits_t limits,
  input wire logic signed [15:0] cascade_setpoint,
  input wire logic signed [15:0] manual_output,
  input wire logic signed [15:0] process_value,
  input wire logic signed [15:0] control_output,
  input wire logic signed [15:0] output_change,
  input wire logic signed [15:0] active_setpoint,
  input wire pid_loop_pkg::mode_t active_mode,
  input wire pid_loop_pkg::alarm_t alarms,
  input wire logic sample_done
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  logic busy_ff;
  logic take;
  logic signed [15:0] pv_now_ff;
  logic signed [15:0] pv_old_ff;
  logic signed [16:0] dpv;
  assign take = sample_tick && !busy_ff;
  assign dpv = pv_now_ff - pv_old_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      pv_now_ff <= 16'sh0000;
      pv_old_ff <= 16'sh0000;
    end else begin
      busy_ff <= take;
      if (take) begin
        pv_now_ff <= process_value;
        pv_old_ff <= pv_now_ff;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ************************************************************
  // Assertions
  // ************************************************************
  AST_DONE_LATENCY: assert property (take |-> ##2 sample_done)
    else $error("sample_done missing two cycles after a tick");
  AST_DONE_CAUSE: assert property (sample_done |-> $past(take, 2))
    else $error("sample_done without a tick");
  AST_OUT_RANGE: assert property (sample_done && active_mode != pid_loop_pkg::MODE_MANUAL
    |-> control_output >= 16'sh0000 && control_output <= pid_loop_pkg::NORM_ONE)
    else $error("computed output outside zero to one");
  AST_MANUAL_OUT: assert property (sample_done && active_mode == pid_loop_pkg::MODE_MANUAL
    |-> control_output == $past(manual_output, 1) && output_change == 16'sh0000)
    else $error("manual output not passed through");
  AST_MODE_ONEHOT: assert property ($onehot(active_mode))
    else $error("mode is not exactly one of three");
  AST_OUT_STABLE: assert property (!sample_done
    |-> $stable(control_output) && ($past(take) || $stable(active_setpoint)))
    else $error("output moved outside a sample");
  AST_CASCADE_SP: assert property (sample_done && active_mode == pid_loop_pkg::MODE_CASCADE
    |-> active_setpoint == $past(cascade_setpoint, 2))
    else $error("cascade setpoint not taken from the other loop");
  AST_RATE_ALARM: assert property (sample_done
    |-> alarms.rate == (dpv > limits.rate || dpv < -limits.rate))
    else $error("rate alarm wrong");
  AST_HIGH_SET: assert property (sample_done && pv_now_ff > limits.high |-> alarms.high)
    else $error("high alarm not raised");
  AST_HIGH_CLEAR: assert property (sample_done
    && pv_now_ff < limits.high - limits.hysteresis |-> !alarms.high)
    else $error("high alarm not cleared");
  AST_LOWLOW_SET: assert property (sample_done && pv_now_ff < limits.low_low
    |-> alarms.low_low)
    else $error("low-low alarm not raised");
  cover property (sample_done && active_mode == pid_loop_pkg::MODE_MANUAL);
  cover property (sample_done && active_mode == pid_loop_pkg::MODE_CASCADE);
  cover property (sample_done && alarms.high_high);
endmodule : pid_loop_controller_monitor

bind pid_loop_controller pid_loop_controller_monitor u_monitor (
  .clk, .rst, .sample_tick, .limits, .cascade_setpoint, .manual_output, .process_value,
  .control_output, .output_change, .active_setpoint, .active_mode, .alarms, .sample_done
);

// ===== verif/test_pid_loop_controller.sv
module test_pid_loop_controller;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals and reference state
  // ************************************************************
  logic clk, rst, sample_tick, cfg_load, transfer_type_two, setpoint_load, sample_done;
  pid_loop_pkg::cfg_t cfg;
  pid_loop_pkg::limits_t limits;
  pid_loop_pkg::mode_t mode_sel, active_mode;
  pid_loop_pkg::alarm_t alarms;
  logic signed [15:0] setpoint_value, cascade_setpoint, manual_output, process_value, pv_next;
  logic signed [15:0] control_output, output_change, bias_term, active_setpoint, actuator;
  int x_out, x_bias, x_chg, x_sp, sp_reg, sp_prev, e_prev, pv1, pv2, mismatches, checks_done;
  bit was_man = 1'b1;
  bit type_two;
  logic [6:0] x_al = 7'h00;
  int seed = 32'hf476b245;
  int pvs[8] = '{16'sh2000, 16'sh3100, 16'sh2f00, 16'sh2d00, 16'sh3900, 16'sh0700, 16'sh0900,
                 16'sh0b00};
  int sps[4] = '{16'sh3000, 16'sh3c00, 16'sh7800, -16'sh3c00};
  pid_loop_pkg::mode_t mds[3] = '{pid_loop_pkg::MODE_MANUAL, pid_loop_pkg::MODE_AUTO,
                                  pid_loop_pkg::MODE_CASCADE};
  pid_loop_controller u_dut (.clk, .rst, .sample_tick, .cfg_load, .transfer_type_two, .cfg,
    .limits, .mode_sel, .setpoint_load, .setpoint_value, .cascade_setpoint, .manual_output,
    .process_value, .control_output, .output_change, .bias_term, .active_setpoint,
    .active_mode, .alarms, .sample_done);
  analog_io_model u_io (.clk, .pv_next, .sample_done, .control_output, .process_value,
    .actuator);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  function automatic int clp(input int v);
    return v < 0 ? 0 : (v > 16384 ? 16384 : v);
  endfunction : clp
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic hys(input int i, input int v, input int l, input bit up);
    if (up ? v > l : v < l) x_al[i] = 1'b1;
    else if (up ? v < l - limits.hysteresis : v > l + limits.hysteresis) x_al[i] = 1'b0;
  endtask : hys
  task automatic model(input int pv, input bit man, input bit casc);
    int kc, ti, td, ts, ki, kr, sp, e, d, m, o, bx, pd, dv;
    kc = cfg.proportional_gain;
    ti = cfg.integral_time;
    td = cfg.derivative_time;
    ts = cfg.sample_period;
    ki = (ti == 9999 || ti == 0) ? 0 : (kc != 0 ? kc * ts / ti : ts * 256 / ti);
    kr = (td == 0 || ts == 0) ? 0 : (kc != 0 ? kc * td / ts : td * 256 / ts);
    sp = casc ? int'(cascade_setpoint) : sp_reg;
    dv = pv > sp ? pv - sp : sp - pv;
    o = x_out;
    if (man) o = manual_output;
    else if (was_man) begin
      if (!cfg.velocity) x_bias = x_out;
      if (!type_two && !casc) begin
        sp = pv;
        sp_reg = pv;
      end
    end else begin
      if (cfg.step_bias && sp != sp_prev && sp != 0 && sp_prev != 0)
        x_bias = clp(cfg.reverse_acting ? x_bias * sp_prev / sp : x_bias * sp / sp_prev);
      e = sp - pv;
      d = pv - pv1;
      pd = ((kc * e) >>> 8) - ((kr * d) >>> 8);
      m = ((kc * (e - e_prev)) >>> 8) + ((ki * (pv - 2 * pv1 + pv2)) >>> 8);
      if (cfg.velocity) o = clp(x_out + m);
      else begin
        bx = x_bias + ((ki * e) >>> 8);
        m = pd + bx;
        o = clp(m);
        if (m == o) x_bias = bx;
        else if (!cfg.freeze_bias) x_bias = clp(o - pd);
      end
    end
    x_chg = (man || was_man) ? 0 : o - x_out;
    hys(6, pv, limits.high_high, 1'b1);
    hys(5, pv, limits.high, 1'b1);
    hys(4, pv, limits.low, 1'b0);
    hys(3, pv, limits.low_low, 1'b0);
    hys(2, dv, limits.yellow_dev, 1'b1);
    hys(1, dv, limits.orange_dev, 1'b1);
    x_al[0] = (pv > pv1 ? pv - pv1 : pv1 - pv) > limits.rate;
    x_out = o;
    x_sp = sp;
    sp_prev = sp;
    e_prev = sp - pv;
    pv2 = pv1;
    pv1 = pv;
    was_man = man;
  endtask : model
  task automatic run(input pid_loop_pkg::mode_t md, input int pv);
    int n;
    pv_next = pv[15:0];
    @(negedge clk);
    mode_sel = md;
    sample_tick = 1'b1;
    @(negedge clk);
    sample_tick = 1'b0;
    n = 0;
    while (sample_done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check(actuator, x_out[15:0]);
    model(pv, md == pid_loop_pkg::MODE_MANUAL, md == pid_loop_pkg::MODE_CASCADE);
    check({15'h0000, sample_done}, 16'h0001);
    check(control_output, x_out[15:0]);
    check(output_change, x_chg[15:0]);
    if (!cfg.velocity) check(bias_term, x_bias[15:0]);
    if (md != pid_loop_pkg::MODE_MANUAL) check(active_setpoint, x_sp[15:0]);
    check({13'h0000, active_mode}, {13'h0000, md});
    check({9'h000, alarms}, {9'h000, x_al});
  endtask : run
  task automatic load_sp(input int v);
    setpoint_value = v[15:0];
    setpoint_load = 1'b1;
    @(negedge clk);
    setpoint_load = 1'b0;
    sp_reg = v;
  endtask : load_sp
  task automatic set_type(input bit t);
    transfer_type_two = t;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    type_two = t;
  endtask : set_type
  task automatic wrap_up;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {sample_tick, cfg_load, transfer_type_two, setpoint_load} = 4'h0;
    {setpoint_value, pv_next} = 32'h0000_0000;
    cascade_setpoint = 16'sh1800;
    manual_output = 16'sh2000;
    mode_sel = pid_loop_pkg::MODE_MANUAL;
    cfg = '{16'h0100, 16'h270f, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b1};
    limits = '{16'sh3800, 16'sh3000, 16'sh1000, 16'sh0800, 16'sh0800, 16'sh1000, 16'sh1000,
               16'sh0200};
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    set_type(1'b0);
    foreach (pvs[i]) run(pid_loop_pkg::MODE_MANUAL, pvs[i]);
    run(pid_loop_pkg::MODE_AUTO, 16'sh1800);
    foreach (sps[i]) begin
      cfg.reverse_acting = i > 1;
      load_sp(sps[i]);
      run(pid_loop_pkg::MODE_AUTO, sps[i]);
    end
    cfg = '{16'h0100, 16'h0001, 16'h0000, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b0};
    load_sp(16'sh1800);
    run(pid_loop_pkg::MODE_AUTO, 16'sh1000);
    cfg.integral_time = 16'h270f;
    cfg.freeze_bias = 1'b1;
    run(pid_loop_pkg::MODE_AUTO, -16'sh3000);
    cfg.freeze_bias = 1'b0;
    run(pid_loop_pkg::MODE_AUTO, -16'sh3000);
    cfg.derivative_time = 16'h0001;
    run(pid_loop_pkg::MODE_AUTO, 16'sh0c00);
    cfg.integral_time = 16'h0001;
    run(pid_loop_pkg::MODE_AUTO, 16'sh1400);
    cfg.proportional_gain = 16'h0000;
    run(pid_loop_pkg::MODE_AUTO, 16'sh1000);
    cfg = '{16'h0100, 16'h0001, 16'h0000, 16'h0001, 1'b0, 1'b1, 1'b0, 1'b0};
    run(pid_loop_pkg::MODE_AUTO, 16'sh1400);
    run(pid_loop_pkg::MODE_AUTO, 16'sh1100);
    cfg.velocity = 1'b0;
    run(pid_loop_pkg::MODE_CASCADE, 16'sh1200);
    set_type(1'b1);
    run(pid_loop_pkg::MODE_MANUAL, 16'sh1000);
    run(pid_loop_pkg::MODE_AUTO, 16'sh1000);
    set_type(1'b0);
    for (int i = 0; i < 30; i++) begin
      manual_output = 16'($random(seed) & 32'h3fff);
      cascade_setpoint = 16'($random(seed) & 32'h3fff);
      cfg.freeze_bias = 1'($random(seed));
      run(mds[($random(seed) & 32'h7fff) % 3], $random(seed) & 32'h1fff);
    end
    wrap_up();
  end
  // The run task already stops waiting for sample_done after four cycles; this caps the whole test at 20000 clocks.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
endmodule : test_pid_loop_controller
